// file: rtl/tdcah_pkg.sv
// Purpose: shared constants for the advanced/test opcode handler
// Assumes: one 40 MHz clock, 16-bit command port
// Notes: opcode high byte selects the command
`default_nettype none
package tdcah_pkg;
   // clock
   localparam int CLK_HZ = 40_000_000;
   // setup chain geometry
   localparam int SETUP_WORDS = 41;
   localparam logic [5:0] LAST_WORD = 6'h28;
   localparam int PAR_BIT = 6;
   localparam logic [15:0] DEFAULT_WORD = 16'h0000;
   // converter side widths
   localparam int ERR_BITS = 11;
   localparam int STAT_BITS = 62;
   localparam logic [5:0] STAT_WORDS = 6'h04;
   localparam logic [5:0] FW_WORDS = 6'h04;
   // opcode high bytes
   localparam logic [7:0] OP_SETUP_WR = 8'h70;
   localparam logic [7:0] OP_SETUP_RD = 8'h71;
   localparam logic [7:0] OP_LOAD = 8'h72;
   localparam logic [7:0] OP_LOAD_DEF = 8'h73;
   localparam logic [7:0] OP_ERR_RD = 8'h74;
   localparam logic [7:0] OP_LOCK_RD = 8'h75;
   localparam logic [7:0] OP_STAT_RD = 8'h76;
   localparam logic [7:0] OP_LOAD_ONE = 8'h77;
   localparam logic [7:0] OP_EE_WR = 8'hC0;
   localparam logic [7:0] OP_EE_RD = 8'hC1;
   localparam logic [7:0] OP_FW_ID = 8'hC2;
   localparam logic [7:0] OP_SPARE_WR = 8'hC3;
   localparam logic [7:0] OP_SPARE_RD = 8'hC4;
   localparam logic [7:0] OP_TEST_ON = 8'hC5;
   localparam logic [7:0] OP_TEST_OFF = 8'hC6;
   localparam logic [7:0] OP_TEST_OUT = 8'hC7;
   localparam logic [7:0] OP_DLL_CLK = 8'hC8;
   localparam logic [7:0] OP_SETUP_DUMP = 8'hC9;
   // eeprom map
   localparam logic [8:0] EE_NOT_EMPTY = 9'h002;
   localparam logic [8:0] EE_BOARD = 9'h003;
   localparam logic [8:0] EE_FW_REV = 9'h004;
   localparam logic [8:0] EE_AUTOLOAD = 9'h008;
   localparam logic [8:0] EE_USER_LO = 9'h018;
   localparam logic [8:0] EE_USER_HI = 9'h028;
   localparam logic [2:0] EE_INIT_LAST = 3'h5;
   // reset values and encodings
   localparam logic [15:0] SPARE_RESET = 16'h5555;
   localparam logic [3:0] TEST_OUT_RESET = 4'hE;
   localparam logic [5:0] TEST_TYPE = 6'h08;
   localparam logic [1:0] DLL_DIRECT_40 = 2'h0;
   localparam logic [1:0] DLL_PLL_40 = 2'h1;
   localparam logic [1:0] DLL_PLL_160 = 2'h2;
   localparam logic [1:0] DLL_PLL_320 = 2'h3;
   // handler states
   typedef enum logic [2:0] {
      ST_INIT = 3'h0,
      ST_IDLE = 3'h1,
      ST_WR = 3'h2,
      ST_FETCH = 3'h3,
      ST_CAP = 3'h4,
      ST_RD = 3'h5,
      ST_LOAD = 3'h6
   } tdcah_state_t;
endpackage : tdcah_pkg
`default_nettype wire

// file: rtl/tdcah_setup_ram.sv
// Purpose: stored copy of the converter setup chain
// Assumes: one write port, one registered read port
// Notes: contents are not reset
`default_nettype none
module tdcah_setup_ram #(
   parameter int DEPTH = 41,
   parameter int AW = 6
) (
   // clock
   input wire logic clk_sys_in,
   // write side
   input wire logic we_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [15:0] wdata_in,
   // read side
   input wire logic [AW-1:0] raddr_in,
   output logic [15:0] rdata_out
);
   logic [15:0] mem [DEPTH];

   // write and registered read
   always_ff @(posedge clk_sys_in)
   begin
      if (we_in)
      begin
         mem[waddr_in] <= wdata_in;
      end
      rdata_out <= mem[raddr_in];
   end
endmodule : tdcah_setup_ram
`default_nettype wire

// file: rtl/tdcah_eeprom.sv
// Purpose: byte-wide non-volatile store model, 512 bytes
// Assumes: single port, write completes in one clock
// Notes: read data is registered
`default_nettype none
module tdcah_eeprom #(
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   // clock
   input wire logic clk_sys_in,
   // access port
   input wire logic we_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [DEPTH];

   // byte write and registered read
   always_ff @(posedge clk_sys_in)
   begin
      if (we_in)
      begin
         mem[addr_in] <= wdata_in;
      end
      rdata_out <= mem[addr_in];
   end
endmodule : tdcah_eeprom
`default_nettype wire

// file: rtl/tdcah_opcode_handler.sv
// Purpose: command port handler for setup, status and test opcodes
// Assumes: host writes an opcode, then data words; reads when ready
// Notes: converter status pins are resynchronised here
`default_nettype none
module tdcah_opcode_handler #(
   parameter int NUM_CONV = 4,
   parameter logic [7:0] NOT_EMPTY_FLAG = 8'hA5, // arbitrary value
   parameter logic [7:0] BOARD_VERSION = 8'h01, // arbitrary value
   parameter logic [7:0] FW_REV = 8'h10, // arbitrary value
   parameter logic [7:0] FW_DAY = 8'h01, // arbitrary value
   parameter logic [7:0] FW_MONTH = 8'h01, // arbitrary value
   parameter logic [7:0] FW_YEAR = 8'h01 // arbitrary value
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // command port
   input wire logic cmd_wr_in,
   input wire logic [15:0] cmd_wdata_in,
   input wire logic cmd_rd_in,
   output logic cmd_wr_ready_out,
   output logic cmd_rd_valid_out,
   output logic [15:0] cmd_rdata_out,
   // converter status pins
   input wire logic [NUM_CONV*tdcah_pkg::ERR_BITS-1:0] conv_err_in,
   input wire logic [NUM_CONV-1:0] conv_lock_in,
   input wire logic [NUM_CONV*tdcah_pkg::STAT_BITS-1:0] conv_status_in,
   // setup stream to converters
   output logic cfg_valid_out,
   output logic [15:0] cfg_word_out,
   output logic [5:0] cfg_index_out,
   output logic cfg_last_out,
   output logic [NUM_CONV-1:0] cfg_target_out,
   // converter controls
   output logic [4*NUM_CONV-1:0] test_sel_out,
   output logic [1:0] dll_clk_sel_out,
   output logic test_mode_out,
   // test event words
   input wire logic trigger_in,
   input wire logic trig_match_in,
   input wire logic [7:0] max_hits_in,
   output logic test_word_valid_out,
   output logic [31:0] test_word_out
);
   import tdcah_pkg::*;

   localparam int SYNC_W = NUM_CONV * (ERR_BITS + 1 + STAT_BITS);

   tdcah_state_t state, next_state;
   logic [15:0] opcode;
   logic [5:0] cnt, total;
   logic [8:0] ee_addr_q;
   logic [2:0] init_cnt;
   logic par_acc;
   logic ld_pend;
   logic [5:0] ld_idx;
   logic [15:0] spare;
   logic [23:0] test_pattern;
   logic [SYNC_W-1:0] sync_a, sync_b;
   logic gen_active;
   logic [1:0] gen_conv;
   logic [7:0] gen_hit;

   logic [7:0] op_hi;
   logic [1:0] conv_n;
   logic wr_take, rd_take, wr_last;
   logic [5:0] ram_raddr;
   logic [15:0] ram_q, ld_src;
   logic ram_we, ee_we;
   logic [8:0] ee_addr;
   logic [7:0] ee_wdata, ee_q;
   logic [NUM_CONV*ERR_BITS-1:0] err_s;
   logic [NUM_CONV-1:0] lock_s;
   logic [NUM_CONV*STAT_BITS-1:0] stat_s;
   logic [63:0] stat_sel;

   // number of data writes an opcode expects
   function automatic logic [5:0] op_writes(input logic [7:0] op);
      case (op)
         OP_SETUP_WR, OP_EE_RD, OP_SPARE_WR: op_writes = 6'h01;
         OP_TEST_OUT, OP_DLL_CLK: op_writes = 6'h01;
         OP_EE_WR, OP_TEST_ON: op_writes = 6'h02;
         default: op_writes = 6'h00;
      endcase
   endfunction : op_writes

   // number of data reads an opcode with no data writes delivers
   function automatic logic [5:0] op_reads(input logic [7:0] op);
      case (op)
         OP_SETUP_RD, OP_ERR_RD, OP_LOCK_RD, OP_SPARE_RD: op_reads = 6'h01;
         OP_STAT_RD: op_reads = STAT_WORDS;
         OP_FW_ID: op_reads = FW_WORDS;
         OP_SETUP_DUMP: op_reads = 6'(SETUP_WORDS);
         default: op_reads = 6'h00;
      endcase
   endfunction : op_reads

   // chain word with the parity bit put in place of host data
   function automatic logic [15:0] chain_word(input logic [15:0] w, input logic [5:0] idx,
                                              input logic acc);
      if (idx == LAST_WORD)
         chain_word = {9'h000, acc ^ (^w[PAR_BIT-1:0]), w[PAR_BIT-1:0]};
      else
         chain_word = w;
   endfunction : chain_word

   // running parity contribution of one chain word
   function automatic logic word_par(input logic [15:0] w, input logic [5:0] idx);
      word_par = (idx == LAST_WORD) ? ^w[PAR_BIT-1:0] : ^w;
   endfunction : word_par

   assign op_hi = opcode[15:8];
   assign conv_n = opcode[1:0];
   assign wr_take = cmd_wr_in && cmd_wr_ready_out;
   assign rd_take = cmd_rd_in && cmd_rd_valid_out;
   assign wr_last = wr_take && state == ST_WR && cnt + 6'h01 == total;
   assign {err_s, lock_s, stat_s} = sync_b;
   assign stat_sel = {2'h0, stat_s[STAT_BITS*conv_n +: STAT_BITS]};
   assign ld_src = (op_hi == OP_LOAD_DEF) ? DEFAULT_WORD : ram_q;

   // two-flop resync of converter pins
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         sync_a <= '0;
         sync_b <= '0;
      end
      else
      begin
         sync_a <= {conv_err_in, conv_lock_in, conv_status_in};
         sync_b <= sync_a;
      end
   end

   // setup copy: host writes land here only
   assign ram_we = wr_take && state == ST_WR && op_hi == OP_SETUP_WR && opcode[7:0] <= 8'h28;
   assign ram_raddr = (op_hi == OP_SETUP_RD) ? opcode[5:0] : cnt;

   tdcah_setup_ram #(.DEPTH(SETUP_WORDS), .AW(6)) u_setup (
      .clk_sys_in(clk_sys_in),
      .we_in(ram_we),
      .waddr_in(opcode[5:0]),
      .wdata_in(cmd_wdata_in),
      .raddr_in(ram_raddr),
      .rdata_out(ram_q)
   );

   // eeprom port steering
   always_comb
   begin
      ee_we = 1'b0;
      ee_wdata = cmd_wdata_in[7:0];
      ee_addr = ee_addr_q;
      if (state == ST_INIT)
      begin
         ee_we = 1'b1;
         ee_addr = EE_NOT_EMPTY + 9'(init_cnt);
         case (init_cnt)
            3'h0: ee_wdata = NOT_EMPTY_FLAG;
            3'h1: ee_wdata = BOARD_VERSION;
            3'h2: ee_wdata = FW_REV;
            3'h3: ee_wdata = FW_DAY;
            3'h4: ee_wdata = FW_MONTH;
            default: ee_wdata = FW_YEAR;
         endcase
      end
      else if (op_hi == OP_EE_WR && state == ST_WR && cnt == 6'h01)
      begin
         ee_we = wr_take;
      end
      else if (op_hi == OP_FW_ID)
      begin
         ee_addr = EE_FW_REV + 9'(cnt);
      end
   end

   tdcah_eeprom #(.DEPTH(512), .AW(9)) u_eeprom (
      .clk_sys_in(clk_sys_in),
      .we_in(ee_we),
      .addr_in(ee_addr),
      .wdata_in(ee_wdata),
      .rdata_out(ee_q)
   );

   // command sequencer
   always_comb
   begin
      next_state = state;
      case (state)
         ST_INIT: if (init_cnt == EE_INIT_LAST) next_state = ST_IDLE;
         ST_IDLE:
         begin
            if (wr_take)
            begin
               if (op_writes(cmd_wdata_in[15:8]) != 6'h00)
                  next_state = ST_WR;
               else if (op_reads(cmd_wdata_in[15:8]) != 6'h00)
                  next_state = ST_FETCH;
               else if (cmd_wdata_in[15:8] inside {OP_LOAD, OP_LOAD_DEF, OP_LOAD_ONE})
                  next_state = ST_LOAD;
            end
         end
         ST_WR: if (wr_last) next_state = (op_hi == OP_EE_RD) ? ST_FETCH : ST_IDLE;
         ST_FETCH: next_state = ST_CAP;
         ST_CAP: next_state = ST_RD;
         ST_RD: if (rd_take) next_state = (cnt + 6'h01 == total) ? ST_IDLE : ST_FETCH;
         ST_LOAD: if (cnt == LAST_WORD) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // state, opcode and write ready handshake flag
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state <= ST_INIT;
         opcode <= 16'h0000;
         init_cnt <= 3'h0;
         cmd_wr_ready_out <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (state == ST_INIT)
            init_cnt <= init_cnt + 3'h1;
         if (state == ST_IDLE && wr_take)
            opcode <= cmd_wdata_in;
         cmd_wr_ready_out <= next_state == ST_WR || (next_state == ST_IDLE && state != ST_LOAD);
      end
   end

   // word counter, expected total and parity accumulator
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         cnt <= 6'h00;
         total <= 6'h00;
         par_acc <= 1'b0;
      end
      else if (state == ST_IDLE && wr_take)
      begin
         cnt <= 6'h00;
         par_acc <= 1'b0;
         total <= (op_writes(cmd_wdata_in[15:8]) != 6'h00) ? op_writes(cmd_wdata_in[15:8])
                  : op_reads(cmd_wdata_in[15:8]);
      end
      else
      begin
         if (wr_last && op_hi == OP_EE_RD)
         begin
            cnt <= 6'h00;
            total <= 6'h01;
         end
         else if ((state == ST_WR && wr_take) || rd_take || state == ST_LOAD)
            cnt <= cnt + 6'h01;
         if (state == ST_CAP && op_hi == OP_SETUP_DUMP)
            par_acc <= par_acc ^ word_par(ram_q, cnt);
         else if (ld_pend)
            par_acc <= par_acc ^ word_par(ld_src, ld_idx);
      end
   end

   // opcode and data writes that set block variables
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         ee_addr_q <= 9'h000;
         spare <= SPARE_RESET;
         test_pattern <= 24'h000000;
         test_mode_out <= 1'b0;
         test_sel_out <= {NUM_CONV{TEST_OUT_RESET}};
         dll_clk_sel_out <= DLL_DIRECT_40;
      end
      else if (state == ST_IDLE && wr_take && cmd_wdata_in[15:8] == OP_TEST_OFF)
         test_mode_out <= 1'b0;
      else if (state == ST_WR && wr_take)
      begin
         case (op_hi)
            OP_EE_WR, OP_EE_RD: if (cnt == 6'h00) ee_addr_q <= cmd_wdata_in[8:0];
            OP_SPARE_WR: spare <= cmd_wdata_in;
            OP_TEST_ON:
            begin
               if (cnt == 6'h00)
                  test_pattern[15:0] <= cmd_wdata_in;
               else
               begin
                  test_pattern[23:16] <= cmd_wdata_in[7:0];
                  test_mode_out <= 1'b1;
               end
            end
            OP_TEST_OUT: test_sel_out[4*conv_n +: 4] <= cmd_wdata_in[3:0];
            OP_DLL_CLK: dll_clk_sel_out <= cmd_wdata_in[1:0];
            default: ;
         endcase
      end
   end

   // read word capture and hold until the host takes it
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         cmd_rd_valid_out <= 1'b0;
         cmd_rdata_out <= 16'h0000;
      end
      else if (state == ST_CAP)
      begin
         cmd_rd_valid_out <= 1'b1;
         case (op_hi)
            OP_SETUP_RD: cmd_rdata_out <= (opcode[7:0] <= 8'h28) ? ram_q : 16'h0000;
            OP_ERR_RD: cmd_rdata_out <= 16'(err_s[ERR_BITS*conv_n +: ERR_BITS]);
            OP_LOCK_RD: cmd_rdata_out <= {15'h0000, lock_s[conv_n]};
            OP_STAT_RD: cmd_rdata_out <= stat_sel[16*cnt[1:0] +: 16];
            OP_EE_RD, OP_FW_ID: cmd_rdata_out <= {8'h00, ee_q};
            OP_SPARE_RD: cmd_rdata_out <= spare;
            OP_SETUP_DUMP: cmd_rdata_out <= chain_word(ram_q, cnt, par_acc);
            default: cmd_rdata_out <= 16'h0000;
         endcase
      end
      else if (rd_take)
         cmd_rd_valid_out <= 1'b0;
   end

   // setup stream to the converters, one word a clock
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         ld_pend <= 1'b0;
         ld_idx <= 6'h00;
         cfg_valid_out <= 1'b0;
         cfg_word_out <= 16'h0000;
         cfg_index_out <= 6'h00;
         cfg_last_out <= 1'b0;
         cfg_target_out <= '0;
      end
      else
      begin
         ld_pend <= state == ST_LOAD;
         ld_idx <= cnt;
         cfg_valid_out <= ld_pend;
         cfg_last_out <= ld_pend && ld_idx == LAST_WORD;
         if (ld_pend)
         begin
            cfg_word_out <= chain_word(ld_src, ld_idx, par_acc);
            cfg_index_out <= ld_idx;
            if (op_hi == OP_LOAD_ONE)
               cfg_target_out <= NUM_CONV'(1) << conv_n;
            else
               cfg_target_out <= '1;
         end
      end
   end

   // test word generator on each trigger in test mode with trig_match_in high, max_hits_in nonzero and no burst running
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         gen_active <= 1'b0;
         gen_conv <= 2'h0;
         gen_hit <= 8'h00;
         test_word_valid_out <= 1'b0;
         test_word_out <= 32'h0000_0000;
      end
      else
      begin
         test_word_valid_out <= gen_active;
         if (gen_active)
         begin
            test_word_out <= {TEST_TYPE, gen_conv, test_pattern};
            gen_hit <= gen_hit + 8'h01;
            if (gen_hit == max_hits_in - 8'h01)
            begin
               gen_hit <= 8'h00;
               gen_conv <= gen_conv + 2'h1;
               if (gen_conv == 2'(NUM_CONV - 1))
                  gen_active <= 1'b0;
            end
         end
         else if (trigger_in && test_mode_out && trig_match_in && max_hits_in != 8'h00)
         begin
            gen_active <= 1'b1;
            gen_conv <= 2'h0;
            gen_hit <= 8'h00;
         end
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   a_read_word_held: assert property (cmd_rd_valid_out && !cmd_rd_in |=> cmd_rd_valid_out && $stable(cmd_rdata_out))
      else $error("read word dropped before the host took it");
   a_read_consumed: assert property (cmd_rd_valid_out && cmd_rd_in |=> !cmd_rd_valid_out)
      else $error("read word not withdrawn after being taken");
   a_status_four: assert property (state == ST_IDLE && wr_take && cmd_wdata_in[15:8] == OP_STAT_RD
                                   |=> total == 6'h04 && state == ST_FETCH)
      else $error("status read does not expect four words");
   a_dump_count: assert property (state == ST_IDLE && wr_take && cmd_wdata_in[15:8] == OP_SETUP_DUMP
                                  |=> total == 6'h29)
      else $error("setup dump does not expect 41 words");
   a_load_length: assert property ($rose(state == ST_LOAD) |-> ##42 (cfg_valid_out && cfg_last_out))
      else $error("setup stream did not end on the 41st word");
   a_single_target: assert property (cfg_valid_out && op_hi == OP_LOAD_ONE |-> $onehot(cfg_target_out))
      else $error("single load reaches more than one converter");
   a_dll_select: assert property (state == ST_WR && wr_take && op_hi == OP_DLL_CLK
                                  |=> dll_clk_sel_out == $past(cmd_wdata_in[1:0]))
      else $error("clock source select not taken from bits 1..0");
   a_test_format: assert property (test_word_valid_out |-> test_word_out[31:26] == TEST_TYPE
                                   && test_word_out[23:0] == test_pattern && test_mode_out)
      else $error("test word carries wrong type or pattern");
   a_spare_store: assert property (state == ST_WR && wr_take && op_hi == OP_SPARE_WR
                                   |=> spare == $past(cmd_wdata_in))
      else $error("spare variable not stored");
endmodule : tdcah_opcode_handler
`default_nettype wire

// file: verification/tdcah_host_model.sv
// Purpose: bus host on the command port
// Assumes: one transfer at a time, driven 1 ns after an edge
// Notes: idle data lines show the inverse of the last word
`default_nettype none
module tdcah_host_model (
   // clock
   input wire logic clk_sys_in,
   // command port
   input wire logic ready_in,
   input wire logic valid_in,
   input wire logic [15:0] rdata_in,
   output logic wr_out,
   output logic rd_out,
   output logic [15:0] wdata_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle levels
   initial
   begin
      wr_out = 1'h0;
      rd_out = 1'h0;
      wdata_out = 16'h0000;
   end
   // write one word, held until ready is seen at an edge
   task wr(input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      #1 wr_out = 1'h1;
      wdata_out = d;
      do @(posedge clk_sys_in); while (ready_in !== 1'h1 && ++n < 99);
      #1 wr_out = 1'h0;
      wdata_out = ~d;
   endtask : wr
   // read one word, taken at the edge where valid is seen
   task rd(output logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      #1 rd_out = 1'h1;
      do @(posedge clk_sys_in); while (valid_in !== 1'h1 && ++n < 99);
      d = rdata_in;
      #1 rd_out = 1'h0;
   endtask : rd
endmodule : tdcah_host_model
`default_nettype wire

// file: verification/tdcah_opcode_handler_tb.sv
// Purpose: self-checking bench for the opcode handler
// Assumes: host model drives the command port
// Notes: expected setup words come from the bench's own chain copy
`default_nettype none
module tdcah_opcode_handler_tb;
   import tdcah_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys_in = 1'h0;
   logic reset_in = 1'h1;
   logic trig = 1'h0;
   logic tmm = 1'h1;
   logic wr, rd, rdy, vld, cv, tm, tv, cl;
   logic [15:0] wd, rdat, cw, w, ts;
   logic [5:0] ci;
   logic [3:0] ct, tgt;
   logic [1:0] dll;
   logic [31:0] tw;
   logic [23:0] tpat;
   logic [7:0] mh = 8'h03;
   logic [43:0] err = '0;
   logic [3:0] lck = '0;
   logic [247:0] st = '0;
   logic [15:0] su [41];
   logic [15:0] ex [41];
   logic [7:0] fw [4] = '{8'h10, 8'h01, 8'h01, 8'h01};
   int err_count = 0;
   int n_checks = 0;
   int ncfg = 0;
   int ntw = 0;
   int k, p;
   tdcah_opcode_handler tdcah_opcode_handler_inst (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .cmd_wr_in(wr), .cmd_wdata_in(wd),
      .cmd_rd_in(rd), .cmd_wr_ready_out(rdy), .cmd_rd_valid_out(vld), .cmd_rdata_out(rdat),
      .conv_err_in(err), .conv_lock_in(lck), .conv_status_in(st), .cfg_valid_out(cv),
      .cfg_word_out(cw), .cfg_index_out(ci), .cfg_last_out(cl), .cfg_target_out(ct),
      .test_sel_out(ts), .dll_clk_sel_out(dll), .test_mode_out(tm), .trigger_in(trig),
      .trig_match_in(tmm), .max_hits_in(mh), .test_word_valid_out(tv), .test_word_out(tw));
   tdcah_host_model tdcah_host_model_inst (.clk_sys_in(clk_sys_in), .ready_in(rdy),
      .valid_in(vld), .rdata_in(rdat), .wr_out(wr), .rd_out(rd), .wdata_out(wd));
   // clock and watchdog
   initial forever #12.5 clk_sys_in = ~clk_sys_in;
   initial
   begin
      #400000;
      err_count++;
      final_report;
   end
   // setup stream and test word monitor
   always @(posedge clk_sys_in)
   begin
      if (cv === 1'h1)
      begin
         chk("cfg", ex[ci], cw);
         chk("tgt", tgt, ct);
         chk("last", ci == 6'h28, cl);
         ncfg++;
      end
      if (tv === 1'h1)
      begin
         chk("tw", {TEST_TYPE, 2'(ntw / mh), tpat}, tw);
         ntw++;
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task wr16(input logic [15:0] d);
      tdcah_host_model_inst.wr(d);
   endtask : wr16
   task rdc(input string nm, input logic [15:0] e);
      logic [15:0] g;
      tdcah_host_model_inst.rd(g);
      chk(nm, e, g);
   endtask : rdc
   task load(input logic [7:0] o, input logic [3:0] t);
      tgt = t;
      ncfg = 0;
      wr16({o, 8'h02});
      repeat (46) @(posedge clk_sys_in);
      chk("count", 41, ncfg);
   endtask : load
   task pulse(input int n);
      ntw = 0;
      @(posedge clk_sys_in);
      #1 trig = 1'h1;
      @(posedge clk_sys_in);
      #1 trig = 1'h0;
      repeat (20) @(posedge clk_sys_in);
      chk("ntw", n, ntw);
   endtask : pulse
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // main sequence
   initial
   begin
      void'($urandom(32'hD751BD5B));
      err = 44'({$urandom(), $urandom()});
      lck = 4'($urandom());
      st = 248'({8{$urandom()}});
      mh = 8'($urandom_range(4, 1));
      repeat (6) @(posedge clk_sys_in);
      #1 reset_in = 1'h0;
      chk("tsel", 16'hEEEE, ts);
      wr16({OP_SPARE_RD, 8'h00});
      rdc("spare", SPARE_RESET);
      w = 16'($urandom());
      wr16({OP_SPARE_WR, 8'h00});
      wr16(w);
      wr16({OP_SPARE_RD, 8'h00});
      rdc("spare", w);
      $display("spare test done");
      for (k = 0; k < 41; k++)
      begin
         su[k] = 16'($urandom());
         wr16({OP_SETUP_WR, 8'(k)});
         wr16(su[k]);
      end
      chk("early", 0, ncfg);
      wr16({OP_SETUP_RD, 8'h28});
      rdc("setup", su[40]);
      ex = su;
      p = ^su[40][5:0];
      for (k = 0; k < 40; k++)
         p = p ^ (^su[k]);
      ex[40] = {9'h000, 1'(p), su[40][5:0]};
      load(OP_LOAD, 4'hF);
      load(OP_LOAD_ONE, 4'h4);
      wr16({OP_SETUP_DUMP, 8'h01});
      for (k = 0; k < 41; k++)
         rdc("dump", ex[k]);
      ex = '{default: DEFAULT_WORD};
      load(OP_LOAD_DEF, 4'hF);
      $display("setup test done");
      for (k = 0; k < 4; k++)
      begin
         wr16({OP_ERR_RD, 8'(k)});
         rdc("err", {5'h00, err[11*k +: 11]});
         wr16({OP_LOCK_RD, 8'(k)});
         rdc("lock", {15'h0000, lck[k]});
         wr16({OP_STAT_RD, 8'(k)});
         for (p = 0; p < 4; p++)
            rdc("stat", p == 3 ? {2'h0, st[62*k+48 +: 14]} : st[62*k+16*p +: 16]);
      end
      $display("status test done");
      // address above the stored-parameter area
      w = 16'h0100 | 16'($urandom_range(255));
      p = $urandom_range(255);
      wr16({OP_EE_WR, 8'h00});
      wr16(w);
      wr16(16'hAB00 | 16'(p));
      wr16({OP_EE_RD, 8'h00});
      wr16(w);
      tdcah_host_model_inst.rd(w);
      chk("ee", p, w[7:0]);
      wr16({OP_FW_ID, 8'h00});
      for (k = 0; k < 4; k++)
      begin
         tdcah_host_model_inst.rd(w);
         chk("fw", fw[k], w[7:0]);
      end
      $display("eeprom test done");
      tpat = 24'($urandom());
      wr16({OP_TEST_ON, 8'h00});
      wr16(tpat[15:0]);
      wr16({8'h5A, tpat[23:16]});
      chk("mode", 1, tm);
      pulse(4 * mh);
      #1 tmm = 1'h0;
      pulse(0);
      #1 tmm = 1'h1;
      wr16({OP_TEST_OFF, 8'h00});
      chk("mode", 0, tm);
      pulse(0);
      for (k = 0; k < 4; k++)
      begin
         w = 16'($urandom());
         wr16({OP_TEST_OUT, 8'(k)});
         wr16(w);
         wr16({OP_DLL_CLK, 8'h00});
         wr16((w & 16'hFFFC) | 16'(k));
         repeat (2) @(posedge clk_sys_in);
         chk("tsel", w[3:0], ts[4*k +: 4]);
         chk("dll", k, dll);
      end
      $display("control test done");
      final_report;
   end
endmodule : tdcah_opcode_handler_tb
`default_nettype wire
